// *** shared/sfc_pkg.sv ***
// Shared constants and types for the serial flash command framing block.
// Assumes one core clock at 50 MHz; the link clock is sampled as data.
package sfc_pkg;

    // Phase widths on the quad data lines.
    typedef enum logic [1:0] {
        SFC_W1,
        SFC_W2,
        SFC_W4
    } sfc_width_t;

    // Decoded view of an instruction byte.
    typedef struct packed {
        logic known;
        logic is_read;
        logic is_write;
        logic is_status;
        logic allowed_busy;
        logic addr4;
        logic byte_checked;
        logic has_mode;
        sfc_width_t width;
        logic [3:0] dummy;
    } sfc_cmd_t;

    // Instruction codes served by this framing layer, and the mode byte that arms an implied read.
    localparam logic [7:0] SFC_OP_READ = 8'h03;
    localparam logic [7:0] SFC_OP_FAST_READ = 8'h0B;
    localparam logic [7:0] SFC_OP_DUAL_IO_READ = 8'hBB;
    localparam logic [7:0] SFC_OP_QUAD_IO_READ = 8'hEB;
    localparam logic [7:0] SFC_OP_READ4 = 8'h13;
    localparam logic [7:0] SFC_OP_PROGRAM = 8'h02;
    localparam logic [7:0] SFC_OP_STATUS = 8'h05;
    localparam logic [7:0] SFC_OP_IMPLIED_HIT = 8'hA0;

    localparam int SFC_INSTR_BITS = 8;
    localparam int SFC_ADDR3_BITS = 24;
    localparam int SFC_ADDR4_BITS = 32;
    localparam int SFC_MODE_BITS = 8;
    localparam logic [3:0] SFC_FAST_DUMMY = 4'h8;
    localparam logic [3:0] SFC_QIO_DUMMY = 4'h4;
    localparam logic [31:0] SFC_ADDR_RESET = 32'h0000_0000;
    localparam logic [5:0] SFC_CNT_RESET = 6'h00;

endpackage : sfc_pkg

// *** rtl/sfc_framer.sv ***
// Device-side command framing for a serial flash with multi-I/O lines.
// Assumes the host drives chip select and the serial clock in mode 0; both are
// sampled by core_clk_i, so the link clock must be well below a quarter of it.
module sfc_framer
    import sfc_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Link pins, asynchronous to core_clk_i.
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic [3:0] quad_data_lines_i,
    output logic [3:0] quad_data_lines_o,
    output logic [3:0] quad_data_lines_oe_n_o,
    // Device core state and configuration.
    input wire logic quad_everything_mode_i,
    input wire logic addr4_mode_i,
    input wire logic write_in_progress_flag_i,
    input wire logic op_failed_i,
    input wire logic [7:0] array_data_i,
    // Command outputs toward the array.
    output logic [ADDR_W-1:0] array_addr_o,
    output logic read_fetch_o,
    output logic cmd_done_o,
    output logic [7:0] cmd_op_o,
    output logic [7:0] wr_data_o,
    output logic wr_valid_o,
    output logic cmd_reject_o
);

    if (ADDR_W != 32) begin : g_addr_w_check
        $error("sfc_framer: ADDR_W must be 32");
    end

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_INSTR,
        ST_ADDR,
        ST_MODE,
        ST_DUMMY,
        ST_DATA,
        ST_SKIP
    } sfc_state_t;

    // Decoding of explicit instructions; implied frames reuse the command decoded in the frame before.
    function automatic sfc_cmd_t sfc_decode(input logic [7:0] op, input logic qmode,
                                            input logic a4);
        sfc_cmd_t c;
        c = '0;
        c.known = 1'b1;
        c.addr4 = a4;
        c.width = SFC_W1;
        case (op)
            SFC_OP_READ: c.is_read = 1'b1;
            SFC_OP_READ4: begin
                c.is_read = 1'b1;
                c.addr4 = 1'b1;
            end
            SFC_OP_FAST_READ: begin
                c.is_read = 1'b1;
                c.dummy = SFC_FAST_DUMMY;
            end
            SFC_OP_DUAL_IO_READ: begin
                c.is_read = 1'b1;
                c.has_mode = 1'b1;
                c.width = SFC_W2;
            end
            SFC_OP_QUAD_IO_READ: begin
                c.is_read = 1'b1;
                c.has_mode = 1'b1;
                c.width = SFC_W4;
                c.dummy = SFC_QIO_DUMMY;
            end
            SFC_OP_PROGRAM: begin
                c.is_write = 1'b1;
                c.byte_checked = 1'b1;
            end
            SFC_OP_STATUS: begin
                c.is_status = 1'b1;
                c.allowed_busy = 1'b1;
            end
            default: c.known = 1'b0;
        endcase
        if (qmode) begin
            c.width = SFC_W4;
        end
        return c;
    endfunction : sfc_decode

    function automatic logic [5:0] sfc_step(input sfc_width_t w);
        case (w)
            SFC_W2: return 6'd2;
            SFC_W4: return 6'd4;
            default: return 6'd1;
        endcase
    endfunction : sfc_step

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection.

    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic sck_prev_r;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Idle pin levels, so that no false link edge follows reset.
            sync1_r <= 6'h20;
            sync2_r <= 6'h20;
            sck_prev_r <= 1'b0;
        end else begin
            sync1_r <= {cs_n_i, sck_i, quad_data_lines_i};
            sync2_r <= sync1_r;
            sck_prev_r <= sync2_r[4];
        end
    end

    logic cs_n_s;
    logic [3:0] din_s;
    logic sck_rise;
    logic sck_fall;
    assign cs_n_s = sync2_r[5];
    assign din_s = sync2_r[3:0];
    assign sck_rise = !cs_n_s && sync2_r[4] && !sck_prev_r;
    assign sck_fall = !cs_n_s && !sync2_r[4] && sck_prev_r;

    ////////////////////////////////////////////////////////////////////////////
    // Command framing state.

    sfc_state_t st_r, st_nxt;
    sfc_cmd_t cmd_r, cmd_nxt;
    logic [7:0] op_r, op_nxt;
    logic [31:0] sh_r, sh_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic [5:0] bits_r, bits_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic implied_r, implied_nxt;
    logic drive_r, drive_nxt;
    logic fetch_r, fetch_nxt;
    logic done_r, done_nxt;
    logic rej_r, rej_nxt;
    logic wrv_r, wrv_nxt;
    logic [7:0] wrd_r, wrd_nxt;

    logic [5:0] step;
    logic [31:0] shin;
    sfc_cmd_t dec;
    assign step = sfc_step(cmd_r.width);
    // Lowest bit of a group on line zero, groups shifted in MSB first.
    always_comb begin
        case (cmd_r.width)
            SFC_W2: shin = {sh_r[29:0], din_s[1:0]};
            SFC_W4: shin = {sh_r[27:0], din_s};
            default: shin = {sh_r[30:0], din_s[0]};
        endcase
    end
    assign dec = sfc_decode(shin[7:0], quad_everything_mode_i, addr4_mode_i);

    always_comb begin
        st_nxt = st_r;
        cmd_nxt = cmd_r;
        op_nxt = op_r;
        sh_nxt = sh_r;
        cnt_nxt = cnt_r;
        bits_nxt = bits_r;
        addr_nxt = addr_r;
        tx_nxt = tx_r;
        implied_nxt = implied_r;
        drive_nxt = drive_r;
        fetch_nxt = 1'b0;
        done_nxt = 1'b0;
        rej_nxt = 1'b0;
        wrv_nxt = 1'b0;
        wrd_nxt = wrd_r;
        if (cs_n_s) begin
            if (st_r != ST_IDLE) begin
                // Byte-checked commands end only on a whole byte.
                if (cmd_r.byte_checked && bits_r[2:0] != 3'd0) begin
                    rej_nxt = 1'b1;
                end else begin
                    done_nxt = st_r != ST_SKIP;
                end
            end
            st_nxt = ST_IDLE;
            drive_nxt = 1'b0;
        end else begin
            if (st_r == ST_IDLE) begin
                sh_nxt = '0;
                cnt_nxt = SFC_CNT_RESET;
                bits_nxt = SFC_CNT_RESET;
                if (implied_r) begin
                    // Implied instruction: the next frame starts at the address.
                    st_nxt = ST_ADDR;
                end else begin
                    cmd_nxt = '0;
                    cmd_nxt.width = quad_everything_mode_i ? SFC_W4 : SFC_W1;
                    st_nxt = ST_INSTR;
                end
            end else if (sck_rise) begin
                sh_nxt = shin;
                cnt_nxt = cnt_r + step;
                bits_nxt = bits_r + step;
                case (st_r)
                    ST_INSTR: if (cnt_r + step == 6'(SFC_INSTR_BITS)) begin
                        op_nxt = shin[7:0];
                        cnt_nxt = '0;
                        cmd_nxt = dec;
                        if (!dec.known) begin
                            st_nxt = ST_SKIP;
                        end else if (write_in_progress_flag_i && !dec.allowed_busy) begin
                            st_nxt = ST_SKIP;
                        end else if (dec.is_status) begin
                            st_nxt = ST_DATA;
                            tx_nxt = {6'h00, op_failed_i, write_in_progress_flag_i};
                        end else begin
                            st_nxt = ST_ADDR;
                        end
                    end
                    ST_ADDR: if (cnt_r + step == (cmd_r.addr4 ? 6'(SFC_ADDR4_BITS)
                                                              : 6'(SFC_ADDR3_BITS))) begin
                        // Whole address bytes, most significant byte first.
                        addr_nxt = cmd_r.addr4 ? shin : {8'h00, shin[23:0]};
                        cnt_nxt = '0;
                        st_nxt = cmd_r.has_mode ? ST_MODE
                               : (cmd_r.dummy != 4'h0) ? ST_DUMMY : ST_DATA;
                        fetch_nxt = cmd_r.is_read && !cmd_r.has_mode && cmd_r.dummy == 4'h0;
                    end
                    ST_MODE: if (cnt_r + step == 6'(SFC_MODE_BITS)) begin
                        implied_nxt = shin[7:4] == SFC_OP_IMPLIED_HIT[7:4];
                        cnt_nxt = '0;
                        st_nxt = (cmd_r.dummy != 4'h0) ? ST_DUMMY : ST_DATA;
                        fetch_nxt = cmd_r.dummy == 4'h0;
                    end
                    ST_DUMMY: if (cnt_r + 6'd1 == {2'b00, cmd_r.dummy}) begin
                        cnt_nxt = '0;
                        st_nxt = ST_DATA;
                        fetch_nxt = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r + 6'd1;
                    end
                    ST_DATA: if (cnt_r + step == 6'd8) begin
                        cnt_nxt = '0;
                        if (cmd_r.is_write) begin
                            wrd_nxt = shin[7:0];
                            wrv_nxt = 1'b1;
                            addr_nxt = addr_r + 32'h0000_0001;
                        end else if (cmd_r.is_read) begin
                            addr_nxt = addr_r + 32'h0000_0001;
                            fetch_nxt = 1'b1;
                        end
                    end
                    default: ;
                endcase
            end else if (sck_fall && st_r == ST_DATA && (cmd_r.is_read || cmd_r.is_status)) begin
                // Output changes on the falling edge, MSB group first.
                drive_nxt = 1'b1;
                case (cmd_r.width)
                    SFC_W2: tx_nxt = (cnt_r == 6'd0) ? tx_r : {tx_r[5:0], 2'b00};
                    SFC_W4: tx_nxt = (cnt_r == 6'd0) ? tx_r : {tx_r[3:0], 4'h0};
                    default: tx_nxt = (cnt_r == 6'd0) ? tx_r : {tx_r[6:0], 1'b0};
                endcase
                if (cnt_r == 6'd0 && cmd_r.is_read) begin
                    tx_nxt = array_data_i;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= ST_IDLE;
            cmd_r <= '0;
            op_r <= 8'h00;
            sh_r <= 32'h0000_0000;
            cnt_r <= SFC_CNT_RESET;
            bits_r <= SFC_CNT_RESET;
            addr_r <= SFC_ADDR_RESET;
            tx_r <= 8'h00;
            implied_r <= 1'b0;
            drive_r <= 1'b0;
            fetch_r <= 1'b0;
            done_r <= 1'b0;
            rej_r <= 1'b0;
            wrv_r <= 1'b0;
            wrd_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            cmd_r <= cmd_nxt;
            op_r <= op_nxt;
            sh_r <= sh_nxt;
            cnt_r <= cnt_nxt;
            bits_r <= bits_nxt;
            addr_r <= addr_nxt;
            tx_r <= tx_nxt;
            implied_r <= implied_nxt;
            drive_r <= drive_nxt;
            fetch_r <= fetch_nxt;
            done_r <= done_nxt;
            rej_r <= rej_nxt;
            wrv_r <= wrv_nxt;
            wrd_r <= wrd_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive: line one alone in single width, low lines first in groups.

    logic [3:0] dout_r, dout_nxt;
    logic [3:0] oen_r, oen_nxt;
    always_comb begin
        dout_nxt = 4'h0;
        oen_nxt = 4'hF;
        if (drive_r && !cs_n_s) begin
            case (cmd_r.width)
                SFC_W2: begin
                    dout_nxt = {2'b00, tx_r[7:6]};
                    oen_nxt = 4'hC;
                end
                SFC_W4: begin
                    dout_nxt = tx_r[7:4];
                    oen_nxt = 4'h0;
                end
                default: begin
                    dout_nxt = {2'b00, tx_r[7], 1'b0};
                    oen_nxt = 4'hD;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dout_r <= 4'h0;
            oen_r <= 4'hF;
        end else begin
            dout_r <= dout_nxt;
            oen_r <= oen_nxt;
        end
    end

    assign quad_data_lines_o = dout_r;
    assign quad_data_lines_oe_n_o = oen_r;
    assign array_addr_o = addr_r;
    assign read_fetch_o = fetch_r;
    assign cmd_done_o = done_r;
    assign cmd_op_o = op_r;
    assign wr_data_o = wrd_r;
    assign wr_valid_o = wrv_r;
    assign cmd_reject_o = rej_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_busy_read;
        st_r == ST_INSTR && sck_rise && cnt_r + step == 6'd8 && write_in_progress_flag_i
            && dec.known && !dec.allowed_busy;
    endsequence

    property p_busy_ignored;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        s_busy_read |=> st_r == ST_SKIP;
    endproperty
    a_busy_ignored: assert property (p_busy_ignored) else $error("busy read not ignored");

    property p_reject_offbyte;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (cs_n_s && st_r != ST_IDLE && cmd_r.byte_checked && bits_r[2:0] != 3'd0)
            |=> cmd_reject_o && !cmd_done_o;
    endproperty
    a_reject_offbyte: assert property (p_reject_offbyte) else $error("off-byte end kept");

    property p_addr_inc;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        wr_valid_o |-> array_addr_o == $past(array_addr_o) + 32'h0000_0001;
    endproperty
    a_addr_inc: assert property (p_addr_inc) else $error("address did not increment");

    property p_no_drive_idle;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        cs_n_s |=> quad_data_lines_oe_n_o == 4'hF;
    endproperty
    a_no_drive_idle: assert property (p_no_drive_idle) else $error("drove while deselected");

    property p_quad_all_width;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (st_r == ST_IDLE && !cs_n_s && !implied_r && quad_everything_mode_i)
            |=> cmd_r.width == SFC_W4;
    endproperty
    a_quad_all_width: assert property (p_quad_all_width) else $error("quad mode not four wide");

    property p_single_out;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (quad_data_lines_oe_n_o != 4'hF && cmd_r.width == SFC_W1)
            |-> quad_data_lines_oe_n_o == 4'hD;
    endproperty
    a_single_out: assert property (p_single_out) else $error("single read off output line");

    property p_instr_first;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (st_r == ST_IDLE && !cs_n_s && !implied_r) |=> st_r == ST_INSTR;
    endproperty
    a_instr_first: assert property (p_instr_first) else $error("no instruction phase");

    property p_dummy_len;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (st_r == ST_DUMMY && sck_rise && cnt_r + 6'd1 != {2'b00, cmd_r.dummy})
            |=> st_r == ST_DUMMY || cs_n_s;
    endproperty
    a_dummy_len: assert property (p_dummy_len) else $error("dummy phase cut short");

endmodule : sfc_framer

// *** tb/sfc_host_model.sv ***
// Behavioural host controller that frames commands on the flash link pins.
// Assumes the bench calls its tasks one at a time; the link clock idles low.
module sfc_host_model (
    // Link pins driven by the host.
    output logic cs_n_o,
    output logic sck_o,
    output logic [3:0] io_o,
    // Resolved level of the quad data lines.
    input wire logic [3:0] io_i
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam time HALF = 80ns;

    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        io_o = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Select goes low a whole period (two HALF waits) before the first rising clock edge.
    task automatic open_frame();
        cs_n_o = 1'b0;
        #(HALF);
    endtask : open_frame

    // Groups leave most significant first, with the group's low bit on line zero.
    task automatic send(input logic [31:0] val, input int nbits, input int w);
        for (int i = nbits; i > 0; i -= w) begin
            logic [3:0] nx;
            nx = ~io_o;
            for (int b = 0; b < w; b++) nx[b] = val[i - w + b];
            io_o = nx;
            #(HALF);
            sck_o = 1'b1;
            #(HALF);
            sck_o = 1'b0;
        end
    endtask : send

    // Released lines toggle every cycle so a stale level never reads as data.
    task automatic recv(output logic [7:0] v, input int w);
        v = 8'h00;
        for (int i = 0; i < 8; i += w) begin
            io_o = ~io_o;
            #(HALF);
            sck_o = 1'b1;
            #(HALF - 1ns);
            case (w)
                1: v = {v[6:0], io_i[1]};
                2: v = {v[5:0], io_i[1:0]};
                default: v = {v[3:0], io_i};
            endcase
            #1ns;
            sck_o = 1'b0;
        end
    endtask : recv

    // The command ends only when select returns high.
    task automatic close_frame();
        #(HALF);
        cs_n_o = 1'b1;
        io_o = ~io_o;
        #(4 * HALF);
    endtask : close_frame

endmodule : sfc_host_model

// *** tb/tb.sv ***
// Self-checking bench for the flash command framer: reads in every width,
// programs, refusals. Assumes the host model of sfc_host_model.sv.
module tb
    import sfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic qmode = 1'b0;
    logic a4 = 1'b0;
    logic busy = 1'b0;
    logic fail = 1'b0;
    logic cs_n, sck, fetch, done, wr_valid, rej, drove;
    logic [3:0] host_io, line, dut_io, dut_oe_n;
    logic [7:0] arr_data, op_seen, wr_data;
    logic [31:0] arr_addr;
    logic [31:0] fetch_q[$];
    logic [7:0] wr_q[$];
    int n_errors = 0;
    int n_tests = 0;
    int n_done, n_rej, seed, t;
    logic [7:0] rd_op [4] = '{SFC_OP_READ, SFC_OP_FAST_READ, SFC_OP_DUAL_IO_READ,
        SFC_OP_QUAD_IO_READ};
    int rd_w [4] = '{1, 1, 2, 4};
    int rd_dummy [4] = '{0, int'(SFC_FAST_DUMMY), 0, int'(SFC_QIO_DUMMY)};

    always #10 core_clk_i = ~core_clk_i;

    // A driving device wins the line; otherwise the host's level is seen.
    assign line = (dut_io & ~dut_oe_n) | (host_io & dut_oe_n);
    assign arr_data = exp_byte(arr_addr);

    sfc_framer #(.ADDR_W(32)) i_dut (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sck_i(sck),
        .quad_data_lines_i(line), .quad_data_lines_o(dut_io),
        .quad_data_lines_oe_n_o(dut_oe_n), .quad_everything_mode_i(qmode),
        .addr4_mode_i(a4), .write_in_progress_flag_i(busy), .op_failed_i(fail),
        .array_data_i(arr_data), .array_addr_o(arr_addr), .read_fetch_o(fetch),
        .cmd_done_o(done), .cmd_op_o(op_seen), .wr_data_o(wr_data),
        .wr_valid_o(wr_valid), .cmd_reject_o(rej));

    sfc_host_model i_host (.cs_n_o(cs_n), .sck_o(sck), .io_o(host_io), .io_i(line));

    // Pulses last one core cycle, so the falling edge sees each exactly once.
    always @(negedge core_clk_i) begin
        if (fetch === 1'b1) fetch_q.push_back(arr_addr);
        if (wr_valid === 1'b1) wr_q.push_back(wr_data);
        if (done === 1'b1) n_done++;
        if (rej === 1'b1) n_rej++;
        if (dut_oe_n !== 4'hF) drove = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] exp_byte(input logic [31:0] a);
        return a[7:0] ^ a[15:8] ^ a[31:24] ^ 8'hC3;
    endfunction : exp_byte

    // Low nibble cleared so a short burst never crosses the top of the space.
    function automatic logic [31:0] rnd_addr(input int ab);
        return $random(seed) & ((ab == 32) ? 32'hFFFF_FFF0 : 32'h00FF_FFF0);
    endfunction : rnd_addr

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic start();
        @(posedge core_clk_i);
        #2;
        fetch_q.delete();
        wr_q.delete();
        n_done = 0;
        n_rej = 0;
        drove = 1'b0;
        i_host.open_frame();
    endtask : start

    task automatic run_read(input logic [7:0] op, input int wi, input int wa, input int ab,
        input int dummy, input int wd, input int nb, input logic [31:0] addr,
        input logic refused, input logic stat);
        logic [7:0] got;
        start();
        i_host.send({24'h0, op}, 8, wi);
        i_host.send(addr, ab, wa);
        // Only the dual and quad I/O reads carry a mode byte; zero keeps implied reads off.
        if (op == SFC_OP_DUAL_IO_READ || op == SFC_OP_QUAD_IO_READ)
            i_host.send(32'h0000_0000, 8, wa);
        i_host.send(32'($random(seed)), dummy, 1);
        for (int k = 0; k < nb; k++) begin
            i_host.recv(got, wd);
            if (stat) check("status", 32'(got), {30'h0, fail, busy});
            else if (!refused) check("rd_byte", 32'(got), 32'(exp_byte(addr + k)));
        end
        i_host.close_frame();
        check("done", n_done, refused ? 0 : 1);
        if (refused) check("drove", 32'(drove), 0);
        else check("op", 32'(op_seen), 32'(op));
        if (!stat && refused) check("no_fetch", fetch_q.size(), 0);
        else if (!stat) check("fetches", fetch_q.size() >= nb, 1);
        for (int k = 0; k < nb && k < fetch_q.size(); k++)
            check("fetch_addr", fetch_q[k], addr + k);
        $display("test read %h done", op);
    endtask : run_read

    task automatic run_prog(input int nb, input int extra);
        logic [7:0] d [$];
        logic [31:0] addr;
        addr = rnd_addr(24);
        start();
        i_host.send({24'h0, SFC_OP_PROGRAM}, 8, 1);
        i_host.send(addr, 24, 1);
        for (int k = 0; k < nb; k++) begin
            d.push_back(8'($random(seed)));
            i_host.send({24'h0, d[k]}, 8, 1);
        end
        i_host.send(32'h0000_0005, extra, 1);
        i_host.close_frame();
        check("wr_count", wr_q.size(), nb);
        for (int k = 0; k < nb && k < wr_q.size(); k++)
            check("wr_byte", 32'(wr_q[k]), 32'(d[k]));
        check("reject", n_rej, extra ? 1 : 0);
        check("done", n_done, extra ? 0 : 1);
        check("drove", 32'(drove), 0);
        $display("test program extra %0d done", extra);
    endtask : run_prog

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(1ms);
        n_errors++;
        test_done();
    end

    initial begin
        seed = 90507;
        repeat (3) @(posedge core_clk_i);
        check("oe_reset", 32'(dut_oe_n), 32'h0000_000F);
        #2 rst_n_i = 1'b1;
        repeat (4) @(posedge core_clk_i);
        for (int a = 0; a < 2; a++) begin
            a4 = (a == 1);
            for (int n = 0; n < 6; n++) begin
                t = (n < 4) ? n : int'($unsigned($random(seed)) % 4);
                run_read(rd_op[t], 1, rd_w[t], a4 ? 32 : 24, rd_dummy[t], rd_w[t],
                    1 + n % 3, rnd_addr(a4 ? 32 : 24), 1'b0, 1'b0);
            end
        end
        a4 = 1'b0;
        run_read(SFC_OP_READ4, 1, 1, 32, 0, 1, 2, rnd_addr(32), 1'b0, 1'b0);
        qmode = 1'b1;
        run_read(SFC_OP_READ, 4, 4, 24, 0, 4, 2, rnd_addr(24), 1'b0, 1'b0);
        qmode = 1'b0;
        run_prog(3, 0);
        run_prog(2, 3);
        busy = 1'b1;
        fail = 1'($random(seed));
        run_read(SFC_OP_READ, 1, 1, 24, 0, 1, 1, rnd_addr(24), 1'b1, 1'b0);
        run_read(SFC_OP_STATUS, 1, 1, 0, 0, 1, 1, 32'h0, 1'b0, 1'b1);
        busy = 1'b0;
        run_read(SFC_OP_STATUS, 1, 1, 0, 0, 1, 1, 32'h0, 1'b0, 1'b1);
        run_read(8'hFF, 1, 1, 0, 0, 1, 1, 32'h0, 1'b1, 1'b0);
        test_done();
    end

endmodule : tb
